// ===== design/ish_core.sv
// interrupt state tracking, selection, acknowledge and completion
// Contract
// RULE1: each interrupt per cpu interface is inactive, pending, active or both.
// RULE2: a request marks the interrupt pending; repeats while pending change nothing.
// RULE3: disabled interrupts are never forwarded but still collect pending state.
// RULE4: per cpu, pick the highest priority enabled pending targeted interrupt.
// RULE5: raise the request only when priority beats mask and running priority.
// RULE6: acknowledge returns the id; pending becomes active, or active and pending.
// RULE7: an asserted level input keeps the interrupt pending through acknowledge.
// RULE8: acknowledging a software interrupt leaves other interfaces untouched.
// RULE9: acknowledging a shared peripheral interrupt clears pending for all targets.
// RULE10: software completes interrupts in reverse order of acknowledgement.
// RULE11: completion write turns active to inactive, active and pending to pending.
// RULE12: with nothing of sufficient priority left, drop the request.
// RULE13: never signal an interrupt that is active and pending.
// RULE14: set-enable bits enable, clear-enable bits disable peripheral interrupts.
// RULE15: set-pending and clear-pending writes set and clear peripheral pending.
// RULE16: clear-pending has no effect on a level interrupt with asserted input.
// RULE17: set-pending makes the interrupt pending whatever the input does.
// RULE18: set- and clear-pending writes never touch software interrupts.
// RULE19: pending and active read back; software bits show any source pending.
// RULE20: trigger register raises software interrupts by list, self or others.
// RULE21: per source pending for software interrupts, one active, source returned.
// RULE22: software interrupt priority is per interface; instances served in turn.
// RULE23: after reset all states are inactive and no request is raised.
`timescale 1ns/1ns
`default_nettype none
`include "ish_consts.svh"
module ish_core (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          resetn,
	// register port
	input  wire ish_pkg::ish_req_t             bus_req,
	output logic [31:0]                        rdata_o,
	// interrupt inputs
	input  wire logic [`ISH_NCPU*`ISH_NPPI-1:0] ppi_in,
	input  wire logic [`ISH_NSPI-1:0]           spi_in,
	// exception requests
	output logic [`ISH_NCPU-1:0]               irq_o
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [`ISH_NCPU-1:0][`ISH_NSGI-1:0][`ISH_NCPU-1:0] sgi_pend_r, sgi_pend_nxt; // [RULE1]
	logic [`ISH_NCPU-1:0][`ISH_NSGI-1:0]                sgi_act_r, sgi_act_nxt;
	logic [`ISH_NCPU-1:0][`ISH_NPPI-1:0]                ppi_lat_r, ppi_lat_nxt;
	logic [`ISH_NCPU-1:0][`ISH_NPPI-1:0]                ppi_act_r, ppi_act_nxt;
	logic [`ISH_NCPU*`ISH_NPPI-1:0]                     ppi_prev_r;
	logic [`ISH_NSPI-1:0]                               spi_lat_r, spi_lat_nxt;
	logic [`ISH_NCPU-1:0][`ISH_NSPI-1:0]                spi_act_r, spi_act_nxt;
	logic [`ISH_NSPI-1:0]                               spi_prev_r;
	logic [`ISH_NSPI-1:0][`ISH_NCPU-1:0]                spi_tgt_r, spi_tgt_nxt;
	ish_pkg::ish_prio_t [`ISH_NCPU-1:0][`ISH_NSGI-1:0]  sgi_prio_r, sgi_prio_nxt;
	ish_pkg::ish_prio_t [`ISH_NCPU-1:0][`ISH_NPPI-1:0]  ppi_prio_r, ppi_prio_nxt;
	ish_pkg::ish_prio_t [`ISH_NSPI-1:0]                 spi_prio_r, spi_prio_nxt;
	ish_pkg::ish_prio_t [`ISH_NCPU-1:0]                 pmask_r, pmask_nxt;
	logic [`ISH_NINT-1:0]                               en_r, en_nxt;
	logic [`ISH_NINT-1:0]                               edge_r, edge_nxt;
	logic                                               ctrl_en_r, ctrl_en_nxt;
	logic [`ISH_NCPU-1:0]                               irq_r;
	logic [31:0]                                        rdata_r, rdata_nxt;
	// ---------------------------------------------------------------
	// effective pending and selection
	// ---------------------------------------------------------------
	logic [`ISH_NCPU-1:0][`ISH_NPPI-1:0]      ppi_pend;
	logic [`ISH_NSPI-1:0]                     spi_pend;
	logic [`ISH_NSPI-1:0]                     spi_any_act;
	logic [`ISH_NCPU-1:0][4:0]                best_p;
	logic [`ISH_NCPU-1:0][4:0]                run_p;
	logic [`ISH_NCPU-1:0][`ISH_IDW-1:0]       best_id;
	logic [`ISH_NCPU-1:0][`ISH_CW-1:0]        best_src;
	logic [`ISH_NCPU-1:0][`ISH_XW-1:0]        best_x;
	ish_pkg::ish_kind_t [`ISH_NCPU-1:0]       best_k;
	logic [`ISH_NCPU-1:0]                     suff;
	always_comb begin
		for (int c = 0; c < `ISH_NCPU; c++) begin
			for (int j = 0; j < `ISH_NPPI; j++) begin
				// level input ORs in live; edge input only via the latch [RULE7] [RULE16]
				ppi_pend[c][j] = ppi_lat_r[c][j] | (~edge_r[`ISH_PPI_LSB+j] & ppi_in[c*`ISH_NPPI+j]);
			end
		end
		for (int i = 0; i < `ISH_NSPI; i++) begin
			spi_pend[i]    = spi_lat_r[i] | (~edge_r[`ISH_SPI_LSB+i] & spi_in[i]);
			spi_any_act[i] = 1'b0;
			for (int c = 0; c < `ISH_NCPU; c++) begin
				spi_any_act[i] = spi_any_act[i] | spi_act_r[c][i];
			end
		end
	end
	// strict less-than keeps the lowest id, then lowest source, on ties [RULE22]
	always_comb begin
		for (int c = 0; c < `ISH_NCPU; c++) begin
			best_p[c]   = `ISH_PRIO_IDLE;
			run_p[c]    = `ISH_PRIO_IDLE;
			best_id[c]  = `ISH_SPURIOUS;
			best_src[c] = '0;
			best_x[c]   = '0;
			best_k[c]   = ish_pkg::KIND_NONE;
			for (int i = 0; i < `ISH_NSGI; i++) begin
				if (sgi_act_r[c][i] && {1'b0, sgi_prio_r[c][i]} < run_p[c]) begin
					run_p[c] = {1'b0, sgi_prio_r[c][i]};
				end
				for (int s = 0; s < `ISH_NCPU; s++) begin
					// suppressed while active on this interface only [RULE13] [RULE21]
					if (sgi_pend_r[c][i][s] && !sgi_act_r[c][i]
						&& {1'b0, sgi_prio_r[c][i]} < best_p[c]) begin
						best_p[c]   = {1'b0, sgi_prio_r[c][i]};
						best_id[c]  = `ISH_IDW'(i);
						best_src[c] = `ISH_CW'(s);
						best_x[c]   = `ISH_XW'(i);
						best_k[c]   = ish_pkg::KIND_SGI;
					end
				end
			end
			for (int j = 0; j < `ISH_NPPI; j++) begin
				if (ppi_act_r[c][j] && {1'b0, ppi_prio_r[c][j]} < run_p[c]) begin
					run_p[c] = {1'b0, ppi_prio_r[c][j]};
				end
				if (ppi_pend[c][j] && en_r[`ISH_PPI_LSB+j] && !ppi_act_r[c][j]
					&& {1'b0, ppi_prio_r[c][j]} < best_p[c]) begin // [RULE4] [RULE13]
					best_p[c]   = {1'b0, ppi_prio_r[c][j]};
					best_id[c]  = `ISH_PPI_BASE + `ISH_IDW'(j);
					best_src[c] = '0;
					best_x[c]   = `ISH_XW'(j);
					best_k[c]   = ish_pkg::KIND_PPI;
				end
			end
			for (int i = 0; i < `ISH_NSPI; i++) begin
				if (spi_act_r[c][i] && {1'b0, spi_prio_r[i]} < run_p[c]) begin
					run_p[c] = {1'b0, spi_prio_r[i]};
				end
				// active anywhere blocks the shared interrupt everywhere [RULE13]
				if (spi_pend[i] && en_r[`ISH_SPI_LSB+i] && spi_tgt_r[i][c] && !spi_any_act[i]
					&& {1'b0, spi_prio_r[i]} < best_p[c]) begin // [RULE4]
					best_p[c]   = {1'b0, spi_prio_r[i]};
					best_id[c]  = `ISH_SPI_BASE + `ISH_IDW'(i);
					best_src[c] = '0;
					best_x[c]   = `ISH_XW'(i);
					best_k[c]   = ish_pkg::KIND_SPI;
				end
			end
			// disabled distributor forwards nothing [RULE3] [RULE5]
			suff[c] = (best_k[c] != ish_pkg::KIND_NONE) && ctrl_en_r
				&& (best_p[c] < {1'b0, pmask_r[c]}) && (best_p[c] < run_p[c]);
		end
	end
	// ---------------------------------------------------------------
	// register port and state transitions
	// ---------------------------------------------------------------
	logic                     ack_go;
	logic [`ISH_IDW-1:0]      ack_id;
	logic [`ISH_CW-1:0]       ack_src;
	logic [`ISH_XW-1:0]       ack_x;
	ish_pkg::ish_kind_t       ack_k;
	logic [`ISH_NINT-1:0]     pend_vec;
	logic [`ISH_NINT-1:0]     act_vec;
	logic [`ISH_NCPU-1:0]     sgit_tgt;
	logic [`ISH_NCPU-1:0]     self_m;
	logic [3:0]               pidx;
	logic [3:0]               sidx;
	logic                     w_setp;
	logic                     w_clrp;
	logic [`ISH_IDW-1:0]      eoi_id;
	assign ack_go  = bus_req.rd && (bus_req.addr == `ISH_A_ACK) && suff[bus_req.cpu];
	assign ack_id  = best_id[bus_req.cpu];
	assign ack_src = best_src[bus_req.cpu];
	assign ack_x   = best_x[bus_req.cpu];
	assign ack_k   = best_k[bus_req.cpu];
	assign pidx    = bus_req.addr[5:2];
	assign sidx    = 4'(pidx - 4'h6);
	assign self_m  = `ISH_NCPU'(1) << bus_req.cpu;
	assign w_setp  = bus_req.wr && (bus_req.addr == `ISH_A_SETP);
	assign w_clrp  = bus_req.wr && (bus_req.addr == `ISH_A_CLRP);
	assign eoi_id  = bus_req.wdata[`ISH_IDW-1:0];
	always_comb begin
		sgi_pend_nxt = sgi_pend_r;
		sgi_act_nxt  = sgi_act_r;
		ppi_lat_nxt  = ppi_lat_r;
		ppi_act_nxt  = ppi_act_r;
		spi_lat_nxt  = spi_lat_r;
		spi_act_nxt  = spi_act_r;
		spi_tgt_nxt  = spi_tgt_r;
		sgi_prio_nxt = sgi_prio_r;
		ppi_prio_nxt = ppi_prio_r;
		spi_prio_nxt = spi_prio_r;
		pmask_nxt    = pmask_r;
		en_nxt       = en_r;
		edge_nxt     = edge_r;
		ctrl_en_nxt  = ctrl_en_r;
		rdata_nxt    = '0;
		sgit_tgt     = bus_req.wdata[`ISH_SGIT_TGT +: `ISH_NCPU];
		// read-back view for the requesting interface [RULE19]
		for (int i = 0; i < `ISH_NSGI; i++) begin
			pend_vec[i] = |sgi_pend_r[bus_req.cpu][i];
			act_vec[i]  = sgi_act_r[bus_req.cpu][i];
		end
		for (int j = 0; j < `ISH_NPPI; j++) begin
			pend_vec[`ISH_PPI_LSB+j] = ppi_pend[bus_req.cpu][j];
			act_vec[`ISH_PPI_LSB+j]  = ppi_act_r[bus_req.cpu][j];
		end
		for (int i = 0; i < `ISH_NSPI; i++) begin
			pend_vec[`ISH_SPI_LSB+i] = spi_pend[i];
			act_vec[`ISH_SPI_LSB+i]  = spi_any_act[i];
		end
		if (bus_req.wr) begin
			case (bus_req.addr)
				`ISH_A_CTRL:  ctrl_en_nxt = bus_req.wdata[0];
				// software interrupts stay permanently enabled [RULE14]
				`ISH_A_SETEN: en_nxt = en_r | bus_req.wdata[`ISH_NINT-1:0];
				`ISH_A_CLREN: en_nxt = (en_r & ~bus_req.wdata[`ISH_NINT-1:0]) | `ISH_EN_FIXED;
				`ISH_A_PMASK: pmask_nxt[bus_req.cpu] = bus_req.wdata[`ISH_PW-1:0];
				`ISH_A_CFG:   edge_nxt = bus_req.wdata[`ISH_NINT-1:0] & ~`ISH_EN_FIXED;
				default: ;
			endcase
			if (bus_req.addr[7:6] == `ISH_A_PRIO_HI) begin
				// software and private priorities are banked per interface [RULE22]
				if (pidx < 4'h4) begin
					sgi_prio_nxt[bus_req.cpu][pidx[1:0]] = bus_req.wdata[`ISH_PW-1:0];
				end else if (pidx < 4'h6) begin
					ppi_prio_nxt[bus_req.cpu][pidx[0]] = bus_req.wdata[`ISH_PW-1:0];
				end else if (pidx < 4'hA) begin
					spi_prio_nxt[sidx[1:0]] = bus_req.wdata[`ISH_PW-1:0];
				end
			end
			if (bus_req.addr[7:4] == `ISH_A_TGT_HI) begin
				spi_tgt_nxt[bus_req.addr[3:2]] = bus_req.wdata[`ISH_NCPU-1:0];
			end
		end
		// clears come first so that a same-cycle set wins
		if (w_clrp) begin // [RULE15] [RULE18]
			for (int j = 0; j < `ISH_NPPI; j++) begin
				if (bus_req.wdata[`ISH_PPI_LSB+j]) ppi_lat_nxt[bus_req.cpu][j] = 1'b0;
			end
			for (int i = 0; i < `ISH_NSPI; i++) begin
				if (bus_req.wdata[`ISH_SPI_LSB+i]) spi_lat_nxt[i] = 1'b0;
			end
		end
		if (ack_go) begin // [RULE6]
			unique case (ack_k)
				ish_pkg::KIND_SGI: begin // [RULE8] [RULE21]
					sgi_pend_nxt[bus_req.cpu][ack_x][ack_src] = 1'b0;
					sgi_act_nxt[bus_req.cpu][ack_x]           = 1'b1;
				end
				ish_pkg::KIND_PPI: begin
					ppi_lat_nxt[bus_req.cpu][ack_x[0]] = 1'b0;
					ppi_act_nxt[bus_req.cpu][ack_x[0]] = 1'b1;
				end
				ish_pkg::KIND_SPI: begin
					// one shared latch: clearing it clears every target [RULE9]
					spi_lat_nxt[ack_x]             = 1'b0;
					spi_act_nxt[bus_req.cpu][ack_x] = 1'b1;
				end
				ish_pkg::KIND_NONE: ;
			endcase
		end
		// completion drops only the active part; pending survives [RULE11] [RULE10]
		if (bus_req.wr && bus_req.addr == `ISH_A_EOI) begin
			for (int i = 0; i < `ISH_NSGI; i++) begin
				if (eoi_id == `ISH_IDW'(i)) sgi_act_nxt[bus_req.cpu][i] = 1'b0;
			end
			for (int j = 0; j < `ISH_NPPI; j++) begin
				if (eoi_id == `ISH_PPI_BASE + `ISH_IDW'(j)) ppi_act_nxt[bus_req.cpu][j] = 1'b0;
			end
			for (int i = 0; i < `ISH_NSPI; i++) begin
				if (eoi_id == `ISH_SPI_BASE + `ISH_IDW'(i)) spi_act_nxt[bus_req.cpu][i] = 1'b0;
			end
		end
		// sets: edges and set-pending writes latch, whatever the enable [RULE2] [RULE3]
		for (int c = 0; c < `ISH_NCPU; c++) begin
			for (int j = 0; j < `ISH_NPPI; j++) begin
				if (edge_r[`ISH_PPI_LSB+j] && ppi_in[c*`ISH_NPPI+j] && !ppi_prev_r[c*`ISH_NPPI+j]) begin
					ppi_lat_nxt[c][j] = 1'b1;
				end
			end
		end
		for (int i = 0; i < `ISH_NSPI; i++) begin
			if (edge_r[`ISH_SPI_LSB+i] && spi_in[i] && !spi_prev_r[i]) spi_lat_nxt[i] = 1'b1;
		end
		if (w_setp) begin // [RULE15] [RULE17]
			for (int j = 0; j < `ISH_NPPI; j++) begin
				if (bus_req.wdata[`ISH_PPI_LSB+j]) ppi_lat_nxt[bus_req.cpu][j] = 1'b1;
			end
			for (int i = 0; i < `ISH_NSPI; i++) begin
				if (bus_req.wdata[`ISH_SPI_LSB+i]) spi_lat_nxt[i] = 1'b1;
			end
		end
		if (bus_req.wr && bus_req.addr == `ISH_A_SGIT) begin // [RULE20] [RULE21]
			if (bus_req.wdata[`ISH_SGIT_FLT +: 2] == `ISH_FLT_OTHERS) sgit_tgt = ~self_m;
			if (bus_req.wdata[`ISH_SGIT_FLT +: 2] == `ISH_FLT_SELF) sgit_tgt = self_m;
			for (int t = 0; t < `ISH_NCPU; t++) begin
				if (sgit_tgt[t]) sgi_pend_nxt[t][bus_req.wdata[`ISH_XW-1:0]][bus_req.cpu] = 1'b1;
			end
		end
		if (bus_req.rd) begin
			case (bus_req.addr)
				`ISH_A_CTRL:                rdata_nxt = 32'(ctrl_en_r);
				`ISH_A_SETEN, `ISH_A_CLREN: rdata_nxt = 32'(en_r);
				`ISH_A_SETP, `ISH_A_CLRP:   rdata_nxt = 32'(pend_vec); // [RULE19]
				`ISH_A_ACT:                 rdata_nxt = 32'(act_vec);
				`ISH_A_PMASK:               rdata_nxt = 32'(pmask_r[bus_req.cpu]);
				`ISH_A_CFG:                 rdata_nxt = 32'(edge_r);
				`ISH_A_ACK:                 rdata_nxt = ack_go ? 32'({ack_src, ack_id})
				                                               : 32'(`ISH_SPURIOUS); // [RULE21]
				default: ;
			endcase
			if (bus_req.addr[7:6] == `ISH_A_PRIO_HI) begin
				if (pidx < 4'h4) begin
					rdata_nxt = 32'(sgi_prio_r[bus_req.cpu][pidx[1:0]]);
				end else if (pidx < 4'h6) begin
					rdata_nxt = 32'(ppi_prio_r[bus_req.cpu][pidx[0]]);
				end else if (pidx < 4'hA) begin
					rdata_nxt = 32'(spi_prio_r[sidx[1:0]]);
				end
			end
			if (bus_req.addr[7:4] == `ISH_A_TGT_HI) rdata_nxt = 32'(spi_tgt_r[bus_req.addr[3:2]]);
		end
	end
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin // [RULE23]
			{sgi_pend_r, sgi_act_r, ppi_lat_r, ppi_act_r, ppi_prev_r} <= '0;
			{spi_lat_r, spi_act_r, spi_prev_r, sgi_prio_r, ppi_prio_r} <= '0;
			{spi_prio_r, pmask_r, edge_r, ctrl_en_r, irq_r, rdata_r} <= '0;
			spi_tgt_r  <= {`ISH_NSPI{`ISH_TGT_RST}};
			en_r       <= `ISH_EN_FIXED;
		end else begin
			sgi_pend_r <= sgi_pend_nxt;
			sgi_act_r  <= sgi_act_nxt;
			ppi_lat_r  <= ppi_lat_nxt;
			ppi_act_r  <= ppi_act_nxt;
			ppi_prev_r <= ppi_in;
			spi_lat_r  <= spi_lat_nxt;
			spi_act_r  <= spi_act_nxt;
			spi_prev_r <= spi_in;
			spi_tgt_r  <= spi_tgt_nxt;
			sgi_prio_r <= sgi_prio_nxt;
			ppi_prio_r <= ppi_prio_nxt;
			spi_prio_r <= spi_prio_nxt;
			pmask_r    <= pmask_nxt;
			en_r       <= en_nxt;
			edge_r     <= edge_nxt;
			ctrl_en_r  <= ctrl_en_nxt;
			irq_r      <= suff; // [RULE5] [RULE12]
			rdata_r    <= rdata_nxt;
		end
	end
	assign irq_o   = irq_r;
	assign rdata_o = rdata_r;
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_reset_quiet: assert property ( // [RULE23]
		@(posedge clk_sys) !resetn |-> (irq_o == '0) && (rdata_o == '0))
		else $error("outputs not quiet during reset");
	a_ack_return: assert property ( // [RULE6]
		@(posedge clk_sys) disable iff (!resetn)
		ack_go |=> rdata_o == 32'({$past(ack_src), $past(ack_id)}))
		else $error("acknowledge returned wrong id or source");
	a_ack_spurious: assert property ( // [RULE12]
		@(posedge clk_sys) disable iff (!resetn)
		(bus_req.rd && bus_req.addr == `ISH_A_ACK && !ack_go) |=> rdata_o[9:0] == 10'h3FF)
		else $error("spurious id missing");
	a_spi_active: assert property ( // [RULE9]
		@(posedge clk_sys) disable iff (!resetn)
		(ack_go && ack_k == ish_pkg::KIND_SPI && spi_in == '0)
		|=> spi_act_r[$past(bus_req.cpu)][$past(ack_x)] && !spi_lat_r[$past(ack_x)])
		else $error("shared acknowledge did not move to active");
	a_sgi_private: assert property ( // [RULE8]
		@(posedge clk_sys) disable iff (!resetn)
		(ack_go && ack_k == ish_pkg::KIND_SGI && bus_req.cpu == 1'b0)
		|=> sgi_pend_r[1] == $past(sgi_pend_r[1]) && sgi_act_r[1] == $past(sgi_act_r[1]))
		else $error("software acknowledge leaked to other interface");
	a_sgi_ignore: assert property ( // [RULE18]
		@(posedge clk_sys) disable iff (!resetn)
		(w_setp || w_clrp) |=> sgi_pend_r == $past(sgi_pend_r))
		else $error("pending write changed software interrupt");
	a_setp_sticky: assert property ( // [RULE17]
		@(posedge clk_sys) disable iff (!resetn)
		(w_setp && bus_req.wdata[`ISH_SPI_LSB]) |=> spi_lat_r[0] ##1 (spi_lat_r[0] || $past(ack_go)
			|| $past(w_clrp)))
		else $error("set-pending did not stick");
	a_eoi_done: assert property ( // [RULE11]
		@(posedge clk_sys) disable iff (!resetn)
		(bus_req.wr && bus_req.addr == `ISH_A_EOI && bus_req.wdata[9:0] == 10'h020
			&& bus_req.cpu == 1'b0) |=> !spi_act_r[0][0])
		else $error("completion left interrupt active");
	a_fwd_gate: assert property ( // [RULE3]
		@(posedge clk_sys) disable iff (!resetn) !ctrl_en_r |=> irq_o == '0)
		else $error("request raised while forwarding disabled");
	a_irq_drop: assert property ( // [RULE12]
		@(posedge clk_sys) disable iff (!resetn) best_k[0] == ish_pkg::KIND_NONE |=> !irq_o[0])
		else $error("request kept with nothing left to signal");
endmodule : ish_core
`default_nettype wire

// ===== inc/ish_consts.svh
// constants of the interrupt state handling block
`ifndef ISH_CONSTS_SVH
`define ISH_CONSTS_SVH
// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define ISH_NCPU       2
`define ISH_CW         1
`define ISH_NSGI       4
`define ISH_NPPI       2
`define ISH_NSPI       4
`define ISH_NINT       10
`define ISH_PW         4
`define ISH_IDW        10
`define ISH_XW         2
// ---------------------------------------------------------------
// interrupt ids and vector layout
// ---------------------------------------------------------------
`define ISH_PPI_BASE   10'h010
`define ISH_SPI_BASE   10'h020
`define ISH_SPURIOUS   10'h3FF
`define ISH_PPI_LSB    4
`define ISH_SPI_LSB    6
`define ISH_ACK_SRC    10
`define ISH_PRIO_IDLE  5'h10
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ISH_A_CTRL     8'h00
`define ISH_A_SETEN    8'h04
`define ISH_A_CLREN    8'h08
`define ISH_A_SETP     8'h0C
`define ISH_A_CLRP     8'h10
`define ISH_A_ACT      8'h14
`define ISH_A_PMASK    8'h18
`define ISH_A_ACK      8'h1C
`define ISH_A_EOI      8'h20
`define ISH_A_SGIT     8'h24
`define ISH_A_CFG      8'h28
`define ISH_A_PRIO_HI  2'h1
`define ISH_A_TGT_HI   4'h8
// ---------------------------------------------------------------
// trigger register fields and reset values
// ---------------------------------------------------------------
`define ISH_SGIT_TGT   16
`define ISH_SGIT_FLT   24
`define ISH_FLT_OTHERS 2'h1
`define ISH_FLT_SELF   2'h2
`define ISH_EN_FIXED   10'h00F
`define ISH_TGT_RST    2'h3
`endif

// ===== inc/ish_pkg.sv
// types of the interrupt state handling block
`include "ish_consts.svh"
package ish_pkg;
	typedef logic [`ISH_PW-1:0] ish_prio_t;
	typedef struct packed {
		logic                 wr;
		logic                 rd;
		logic [7:0]           addr;
		logic [31:0]          wdata;
		logic [`ISH_CW-1:0]   cpu;
	} ish_req_t;
	typedef enum logic [3:0] {
		KIND_NONE = 4'b0001,
		KIND_SGI  = 4'b0010,
		KIND_PPI  = 4'b0100,
		KIND_SPI  = 4'b1000
	} ish_kind_t;
endpackage : ish_pkg

// ===== test/irq_state_handling_tb.sv
// self-checking bench of the interrupt state block
`timescale 1ns/1ns
`default_nettype none
`include "ish_consts.svh"
module irq_state_handling_tb;
	typedef struct {
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] ex;
	} ish_row_t;
	logic              clk_sys;
	logic              resetn;
	logic [3:0]        spi_in;
	logic [3:0]        ppi_in;
	logic [31:0]       rdata_o;
	logic [31:0]       q;
	logic [1:0]        irq_o;
	ish_pkg::ish_req_t bus_req;
	int                mismatches;
	int                n_tests;
	ish_row_t          rows[6] = '{
		'{`ISH_A_SETEN, 32'h40, `ISH_A_SETEN, 32'h4F},
		'{`ISH_A_CLREN, 32'h3FF, `ISH_A_SETEN, 32'hF},
		'{`ISH_A_SETP, 32'h40, `ISH_A_SETP, 32'h40},
		'{`ISH_A_CLRP, 32'h40, `ISH_A_SETP, 32'h0},
		'{`ISH_A_SETP, 32'hF, `ISH_A_CLRP, 32'h0},
		'{8'hFC, 32'hFFFF, 8'hFC, 32'h0}};
	ish_core u_ish_core (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
		.rdata_o(rdata_o), .ppi_in(ppi_in), .spi_in(spi_in), .irq_o(irq_o));
	ish_cpu u_ish_cpu (.clk_sys(clk_sys), .rdata_o(rdata_o), .bus_req(bus_req));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] ex);
		n_tests++;
		if (got !== ex) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask : chk
	task ci(input logic [1:0] e);
		chk({30'h0, irq_o}, {30'h0, e});
	endtask : ci
	task wr(input logic [7:0] a, input logic [31:0] d, input logic c);
		u_ish_cpu.acc(1'b1, a, d, c, q);
	endtask : wr
	task rc(input logic [7:0] a, input logic c, input logic [31:0] e);
		u_ish_cpu.acc(1'b0, a, 32'h0, c, q);
		chk(q, e);
	endtask : rc
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wt
	// one-cycle rising pulse on the private input of cpu 0, id 16
	task pulse;
		@(posedge clk_sys);
		ppi_in <= 4'h1;
		@(posedge clk_sys);
		ppi_in <= 4'h0;
		wt(2);
	endtask : pulse
	task final_report;
		$display("tests=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// whole run is under two hundred cycles
	initial begin
		#2000000;
		mismatches++;
		final_report;
	end
	initial begin
		resetn = 1'b0;
		spi_in = 4'h0;
		ppi_in = 4'h0;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		wt(1);
		ci(2'b00);
		rc(`ISH_A_ACT, 1'b0, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd, 1'b0);
			rc(rows[i].ra, 1'b0, rows[i].ex);
		end
		$display("test rows done");
		wr(`ISH_A_CTRL, 32'h1, 1'b0);
		wr(`ISH_A_SETEN, 32'h40, 1'b0);
		wr(8'h58, 32'h5, 1'b0);
		wr(`ISH_A_PMASK, 32'h5, 1'b0);
		wr(`ISH_A_PMASK, 32'hF, 1'b1);
		@(posedge clk_sys);
		spi_in <= 4'h1;
		wt(3);
		ci(2'b10);
		wr(`ISH_A_PMASK, 32'h6, 1'b0);
		wt(2);
		ci(2'b11);
		rc(`ISH_A_ACK, 1'b0, 32'h20);
		wt(2);
		ci(2'b00);
		rc(`ISH_A_ACT, 1'b1, 32'h40);
		rc(`ISH_A_SETP, 1'b0, 32'h40);
		wr(`ISH_A_CLRP, 32'h40, 1'b0);
		rc(`ISH_A_SETP, 1'b0, 32'h40);
		@(posedge clk_sys);
		spi_in <= 4'h0;
		wt(2);
		rc(`ISH_A_SETP, 1'b0, 32'h0);
		wr(`ISH_A_EOI, 32'h20, 1'b0);
		rc(`ISH_A_ACT, 1'b0, 32'h0);
		ci(2'b00);
		$display("test shared level done");
		wr(`ISH_A_CLREN, 32'h40, 1'b0);
		wr(`ISH_A_SETP, 32'h40, 1'b0);
		wt(2);
		ci(2'b00);
		rc(`ISH_A_SETP, 1'b0, 32'h40);
		wr(`ISH_A_SETEN, 32'h40, 1'b0);
		wt(2);
		ci(2'b11);
		rc(`ISH_A_ACK, 1'b1, 32'h20);
		rc(`ISH_A_SETP, 1'b0, 32'h0);
		wr(`ISH_A_EOI, 32'h20, 1'b1);
		rc(`ISH_A_ACT, 1'b1, 32'h0);
		$display("test disabled done");
		u_ish_cpu.trig(1'b0, 2'h0, 2'h3, 2'h1);
		wt(2);
		ci(2'b11);
		rc(`ISH_A_ACK, 1'b0, 32'h1);
		rc(`ISH_A_SETP, 1'b1, 32'h2);
		u_ish_cpu.trig(1'b1, 2'h0, 2'h1, 2'h1);
		rc(`ISH_A_ACK, 1'b0, 32'h3FF);
		wr(`ISH_A_EOI, 32'h1, 1'b0);
		rc(`ISH_A_ACK, 1'b0, 32'h401);
		wr(`ISH_A_EOI, 32'h1, 1'b0);
		u_ish_cpu.serve(1'b1, q);
		chk(q, 32'h1);
		u_ish_cpu.trig(1'b1, 2'h2, 2'h0, 2'h2);
		u_ish_cpu.trig(1'b0, 2'h1, 2'h0, 2'h3);
		rc(`ISH_A_SETP, 1'b1, 32'hC);
		rc(`ISH_A_SETP, 1'b0, 32'h0);
		u_ish_cpu.serve(1'b1, q);
		chk(q, 32'h402);
		u_ish_cpu.serve(1'b1, q);
		chk(q, 32'h3);
		wt(2);
		ci(2'b00);
		$display("test software done");
		wr(`ISH_A_CFG, 32'h3F, 1'b0);
		rc(`ISH_A_CFG, 1'b0, 32'h30);
		wr(`ISH_A_SETEN, 32'h30, 1'b0);
		pulse;
		ci(2'b01);
		rc(`ISH_A_SETP, 1'b1, 32'h0);
		rc(`ISH_A_ACK, 1'b0, 32'h10);
		rc(`ISH_A_SETP, 1'b0, 32'h0);
		pulse;
		ci(2'b00);
		rc(`ISH_A_SETP, 1'b0, 32'h10);
		rc(`ISH_A_ACT, 1'b0, 32'h10);
		wr(`ISH_A_EOI, 32'h10, 1'b0);
		wt(1);
		ci(2'b01);
		$display("test private edge done");
		@(posedge clk_sys);
		resetn <= 1'b0;
		wt(2);
		ci(2'b00);
		@(posedge clk_sys);
		resetn <= 1'b1;
		wt(1);
		ci(2'b00);
		rc(`ISH_A_SETP, 1'b0, 32'h0);
		rc(`ISH_A_CFG, 1'b0, 32'h0);
		$display("test reset again done");
		final_report;
	end
endmodule : irq_state_handling_tb
`default_nettype wire

// ===== test/ish_cpu.sv
// processor-side bus master model for the interrupt state block
`timescale 1ns/1ns
`default_nettype none
`include "ish_consts.svh"
module ish_cpu (
	// clock
	input  wire logic             clk_sys,
	// register port
	input  wire logic [31:0]      rdata_o,
	output var ish_pkg::ish_req_t bus_req
);
	initial bus_req = '0;
	// strobe held across the sampling edge; read data taken in the next cycle only
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
		output logic [31:0] q);
		@(posedge clk_sys);
		bus_req <= '{wr: w, rd: !w, addr: a, wdata: d, cpu: c};
		@(posedge clk_sys);
		bus_req <= '0;
		#1 q = rdata_o;
	endtask : acc
	task trig(input logic c, input logic [1:0] flt, input logic [1:0] tgt, input logic [1:0] id);
		logic [31:0] q;
		acc(1'b1, `ISH_A_SGIT, {6'h0, flt, 6'h0, tgt, 14'h0, id}, c, q);
	endtask : trig
	// complete at once, so the latest acknowledged is always completed first
	task serve(input logic c, output logic [31:0] id);
		logic [31:0] q;
		acc(1'b0, `ISH_A_ACK, 32'h0, c, id);
		acc(1'b1, `ISH_A_EOI, {22'h0, id[9:0]}, c, q);
	endtask : serve
endmodule : ish_cpu
`default_nettype wire
